//--- floppy_data_recovery_precomp.sv
/*
  Package of constants and the floppy support logic top module.
  Assumes all inputs are asynchronous pins, pull-ups live in the pad ring,
  and the two-way pump pins are resolved outside from the enables.
*/
// How it works
// - Write gate high disables recovery, pumps float
// - Recovery runs only with fault and gate low
// - Early read edge drives raise output high
// - Late read edge drives lower output low
// - Centred read edge leaves both pumps floating
// - Window clock is oscillator over 16 or 8
// - Pump stays active while read pulse low
// - Hints pick phase on write leading edge
// - Write leading edge raises phase strobe
// - Fourth phase leading edge drops strobe
// - Single density or outer track bypasses precompensation
// - Open density, track, read inputs read one
package fsl_pkg;

  // Window counter and divide ratios
  localparam int unsigned CNT_W        = 4;
  localparam logic [4:0]  DIV_SINGLE   = 5'h10;
  localparam logic [4:0]  DIV_DOUBLE   = 5'h08;
  localparam int unsigned RCLK_BIT_SD  = 3;
  localparam int unsigned RCLK_BIT_DD  = 2;

  // Centre zone bounds, in eighths of a window
  localparam logic [4:0]  CENTRE_LO_8THS = 5'h03;
  localparam logic [4:0]  CENTRE_HI_8THS = 5'h05;
  localparam int unsigned EIGHTH_SHIFT   = 3;

  // Positions of pins inside the synchroniser vector
  localparam int unsigned SYNC_W   = 13;
  localparam int unsigned S_OSC    = 0;
  localparam int unsigned S_READ   = 1;
  localparam int unsigned S_WRITE  = 2;
  localparam int unsigned S_GATE   = 3;
  localparam int unsigned S_FAULT  = 4;
  localparam int unsigned S_DDN    = 5;
  localparam int unsigned S_TRK    = 6;
  localparam int unsigned S_AHEAD  = 7;
  localparam int unsigned S_BEHIND = 8;
  localparam int unsigned S_PH     = 9;

  // Idle levels: read, density, track and phases high
  localparam logic [SYNC_W-1:0] SYNC_RESET = 13'h1e62;

  // Phase index within the four phase inputs
  localparam logic [1:0] PH_EARLY   = 2'h0;
  localparam logic [1:0] PH_NOMINAL = 2'h1;
  localparam logic [1:0] PH_LATE    = 2'h2;
  localparam logic [1:0] PH_LAST    = 2'h3;

  typedef enum logic [1:0] {PUMP_IDLE, PUMP_RAISE, PUMP_LOWER} pump_t;
  typedef enum logic [1:0] {ZONE_EARLY, ZONE_CENTRE, ZONE_LATE} zone_t;

  typedef struct packed {
    logic [CNT_W-1:0] win_cnt;
    logic             osc_prev;
    logic             read_prev;
    logic             write_prev;
    logic             ph_last_prev;
    pump_t            pump;
    logic             strobe;
    logic [1:0]       phase_sel;
    logic             rclk;
    logic             write_out;
  } core_t;

endpackage

`timescale 1ns/1ps
module floppy_data_recovery_precomp (
  input  wire logic                clk_i,
  input  wire logic                resetn_i,
  input  wire logic                osc_master_i,
  input  wire logic                disk_read_pulse_n_i,
  input  wire logic                raw_write_i,
  input  wire logic                write_gate_i,
  input  wire logic                recovery_enable_fault_i,
  input  wire logic                double_density_sel_n_i,
  input  wire logic                inner_track_flag_i,
  input  wire logic                shift_ahead_sel_i,
  input  wire logic                shift_behind_sel_i,
  input  wire logic [3:0]          phase_n_i,
  output logic                     read_window_clock_o,
  output logic                     freq_raise_req_o,
  output logic                     freq_raise_req_oe_o,
  output logic                     freq_lower_req_o,
  output logic                     freq_lower_req_oe_o,
  output logic                     phase_strobe_o,
  output logic                     comp_write_o
);
  import fsl_pkg::*;

  logic [SYNC_W-1:0] pins_async;
  logic [SYNC_W-1:0] pins;
  fsl_pkg::core_t    state_ff;
  fsl_pkg::core_t    nxt_state;

  // Window position into early, centre or late zone
  function automatic zone_t window_zone(input logic [CNT_W-1:0] cnt,
                                        input logic             single_den);
    logic [4:0] win;
    logic [4:0] pos;
    logic [4:0] lo;
    logic [4:0] hi;
    win = single_den ? DIV_SINGLE : DIV_DOUBLE;
    pos = single_den ? {1'b0, cnt} : {2'b00, cnt[RCLK_BIT_DD:0]};
    lo  = 5'((10'(win) * 10'(CENTRE_LO_8THS)) >> EIGHTH_SHIFT);
    hi  = 5'((10'(win) * 10'(CENTRE_HI_8THS)) >> EIGHTH_SHIFT);
    if (pos < lo) begin
      window_zone = ZONE_EARLY;
    end else if (pos < hi) begin
      window_zone = ZONE_CENTRE;
    end else begin
      window_zone = ZONE_LATE;
    end
  endfunction

  // Gather every pin into one vector for the synchroniser
  always_comb begin
    pins_async                      = '0;
    pins_async[S_OSC]               = osc_master_i;
    pins_async[S_READ]              = disk_read_pulse_n_i;
    pins_async[S_WRITE]             = raw_write_i;
    pins_async[S_GATE]              = write_gate_i;
    pins_async[S_FAULT]             = recovery_enable_fault_i;
    pins_async[S_DDN]               = double_density_sel_n_i;
    pins_async[S_TRK]               = inner_track_flag_i;
    pins_async[S_AHEAD]             = shift_ahead_sel_i;
    pins_async[S_BEHIND]            = shift_behind_sel_i;
    pins_async[S_PH +: 4]           = phase_n_i;
  end

  // Idle-high reset values stand for open pulled-up pins
  pin_sync #(
    .WIDTH     (SYNC_W),
    .RESET_VAL (SYNC_RESET)
  ) u_pin_sync (
    .clk_i     (clk_i),
    .resetn_i  (resetn_i),
    .async_i   (pins_async),
    .sync_o    (pins)
  );

  // Next state of the recovery and precompensation logic
  always_comb begin
    logic  osc_rise;
    logic  read_fall;
    logic  write_rise;
    logic  ph_last_fall;
    logic  single_den;
    logic  rec_enable;
    logic  precomp_on;
    logic  in_window_sel;
    zone_t zone;

    nxt_state    = state_ff;
    single_den   = pins[S_DDN];
    osc_rise     = pins[S_OSC] & ~state_ff.osc_prev;
    read_fall    = ~pins[S_READ] & state_ff.read_prev;
    write_rise   = pins[S_WRITE] & ~state_ff.write_prev;
    ph_last_fall = ~pins[S_PH + PH_LAST] & state_ff.ph_last_prev;
    rec_enable   = ~pins[S_GATE] & ~pins[S_FAULT];
    precomp_on   = ~single_den & pins[S_TRK];
    zone         = window_zone(state_ff.win_cnt, single_den);
    in_window_sel = ~pins[S_PH + state_ff.phase_sel];

    nxt_state.osc_prev     = pins[S_OSC];
    nxt_state.read_prev    = pins[S_READ];
    nxt_state.write_prev   = pins[S_WRITE];
    nxt_state.ph_last_prev = pins[S_PH + PH_LAST];

    // Window counter advances once per oscillator cycle
    if (osc_rise) begin
      nxt_state.win_cnt = state_ff.win_cnt + CNT_W'(1);
    end
    nxt_state.rclk = single_den ? state_ff.win_cnt[RCLK_BIT_SD]
                                : state_ff.win_cnt[RCLK_BIT_DD];

    // Pump direction picked at the read edge, held while low
    if (!rec_enable) begin
      nxt_state.pump = PUMP_IDLE;
    end else if (read_fall) begin
      unique case (zone)
        ZONE_EARLY:  nxt_state.pump = PUMP_RAISE;
        ZONE_LATE:   nxt_state.pump = PUMP_LOWER;
        ZONE_CENTRE: nxt_state.pump = PUMP_IDLE;
      endcase
    end else if (pins[S_READ]) begin
      nxt_state.pump = PUMP_IDLE;
    end

    // Strobe: set on write leading edge, cleared by last phase
    if (precomp_on && write_rise) begin
      nxt_state.strobe = 1'b1;
      if (pins[S_AHEAD] && !pins[S_BEHIND]) begin
        nxt_state.phase_sel = PH_EARLY;
      end else if (pins[S_BEHIND] && !pins[S_AHEAD]) begin
        nxt_state.phase_sel = PH_LATE;
      end else begin
        nxt_state.phase_sel = PH_NOMINAL;
      end
    end else if (ph_last_fall || !precomp_on) begin
      nxt_state.strobe = 1'b0;
    end

    // Write data: chosen phase gated by strobe, straight copy in bypass
    if (precomp_on) begin
      nxt_state.write_out = state_ff.strobe & in_window_sel;
    end else begin
      nxt_state.write_out = pins[S_WRITE];
    end
  end

  // Single state register
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_ff <= '{win_cnt:      '0,
                    osc_prev:     1'b0,
                    read_prev:    1'b1,
                    write_prev:   1'b0,
                    ph_last_prev: 1'b1,
                    pump:         PUMP_IDLE,
                    strobe:       1'b0,
                    phase_sel:    PH_NOMINAL,
                    rclk:         1'b0,
                    write_out:    1'b0};
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Pump pins: raise drives one, lower drives zero, else float
  assign freq_raise_req_oe_o = (state_ff.pump == PUMP_RAISE);
  assign freq_raise_req_o    = 1'b1;
  assign freq_lower_req_oe_o = (state_ff.pump == PUMP_LOWER);
  assign freq_lower_req_o    = 1'b0;

  assign read_window_clock_o = state_ff.rclk;
  assign phase_strobe_o      = state_ff.strobe;
  assign comp_write_o        = state_ff.write_out;

endmodule

//--- pin_sync.sv
/*
  Two-stage synchroniser for a vector of asynchronous pin inputs.
  Assumes every bit is independent; multi-bit coherence is not kept.
*/
`timescale 1ns/1ps
module pin_sync #(
  parameter int unsigned            WIDTH     = 1,
  parameter logic [WIDTH-1:0]       RESET_VAL = '0
) (
  input  wire logic                 clk_i,
  input  wire logic                 resetn_i,
  input  wire logic [WIDTH-1:0]     async_i,
  output logic      [WIDTH-1:0]     sync_o
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_state_t;

  sync_state_t state_ff;
  sync_state_t nxt_state;

  // First stage feeds only the second stage
  always_comb begin
    nxt_state.meta   = async_i;
    nxt_state.stable = state_ff.meta;
  end

  // Both stages reset to the idle level of each pin
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_ff <= '{meta: RESET_VAL, stable: RESET_VAL};
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign sync_o = state_ff.stable;

endmodule

//--- fsl_props.sv
/* Port checker for the floppy support logic.
   Assumes it is bound to the top module and sees only its ports. */
`timescale 1ns/1ps
module fsl_props (
  input wire logic       clk_i,
  input wire logic       resetn_i,
  input wire logic       disk_read_pulse_n_i,
  input wire logic       raw_write_i,
  input wire logic       write_gate_i,
  input wire logic       double_density_sel_n_i,
  input wire logic       inner_track_flag_i,
  input wire logic [3:0] phase_n_i,
  input wire logic       freq_raise_req_o,
  input wire logic       freq_raise_req_oe_o,
  input wire logic       freq_lower_req_o,
  input wire logic       freq_lower_req_oe_o,
  input wire logic       phase_strobe_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);
  // Pump outputs against read, gate and levels
  gate_float_a: assert property (write_gate_i [*4] |->
    !(freq_raise_req_oe_o | freq_lower_req_oe_o)) else $error("pump on in write");
  idle_float_a: assert property (disk_read_pulse_n_i [*4] |->
    !(freq_raise_req_oe_o | freq_lower_req_oe_o)) else $error("pump on while idle");
  pump_one_a: assert property (!(freq_raise_req_oe_o && freq_lower_req_oe_o))
    else $error("both pumps on");
  raise_high_a: assert property (freq_raise_req_oe_o |-> freq_raise_req_o)
    else $error("raise not high");
  lower_low_a: assert property (freq_lower_req_oe_o |-> !freq_lower_req_o)
    else $error("lower not low");
  pump_cause_a: assert property ($rose(freq_raise_req_oe_o | freq_lower_req_oe_o) |->
    !$past(disk_read_pulse_n_i, 2)) else $error("pump without read");
  // Strobe set and clear timing
  strobe_set_a: assert property ($rose(raw_write_i) && !double_density_sel_n_i &&
    inner_track_flag_i |-> ##[2:4] phase_strobe_o) else $error("strobe not set");
  strobe_clr_a: assert property ($fell(phase_n_i[3]) |-> ##[1:4] !phase_strobe_o)
    else $error("strobe not cleared");
  cover property ($rose(freq_raise_req_oe_o));
  cover property ($rose(freq_lower_req_oe_o));
  cover property ($fell(phase_strobe_o));
endmodule
bind floppy_data_recovery_precomp fsl_props u_props (
  .clk_i                  (clk_i),
  .resetn_i               (resetn_i),
  .disk_read_pulse_n_i    (disk_read_pulse_n_i),
  .raw_write_i            (raw_write_i),
  .write_gate_i           (write_gate_i),
  .double_density_sel_n_i (double_density_sel_n_i),
  .inner_track_flag_i     (inner_track_flag_i),
  .phase_n_i              (phase_n_i),
  .freq_raise_req_o       (freq_raise_req_o),
  .freq_raise_req_oe_o    (freq_raise_req_oe_o),
  .freq_lower_req_o       (freq_lower_req_o),
  .freq_lower_req_oe_o    (freq_lower_req_oe_o),
  .phase_strobe_o         (phase_strobe_o)
);

//--- fsl_far_model.sv
/* Far side model: oscillator and four phase generator.
   Assumes the strobe is a level in the clk_i domain. */
`timescale 1ns/1ps
module fsl_far_model #(
  parameter int HALF = 25
) (
  input  wire logic       clk_i,
  input  wire logic       strobe_i,
  output logic            osc_o,
  output logic [3:0]      phase_n_o
);
  int   tick = 0;
  int   step = 99;
  logic seen = 1'b0;
  initial osc_o = 1'b0;
  // Free oscillator and phase step count from strobe rise
  always @(posedge clk_i) begin
    tick <= (tick == HALF - 1) ? 0 : tick + 1;
    osc_o <= (tick == HALF - 1) ? ~osc_o : osc_o;
    seen <= strobe_i;
    step <= (strobe_i && !seen) ? 1 : ((step < 99) ? step + 1 : 99);
  end
  // Phase k low for steps 20k+10 to 20k+19
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      phase_n_o[k] = !(step >= 20 * k + 10 && step < 20 * k + 20);
    end
  end
endmodule

//--- testbench.sv
/* Testbench for the floppy support logic.
   Assumes the far side model supplies oscillator and phases. */
`timescale 1ns/1ps
module testbench;
  logic       clk_i = 1'b0;
  logic       resetn_i = 1'b0;
  logic       read_n = 1'b1;
  logic       wr_data = 1'b0;
  logic       wr_gate = 1'b0;
  logic       fault = 1'b0;
  logic       dd_n = 1'b0;
  logic       trk = 1'b1;
  logic       ahead = 1'b0;
  logic       behind = 1'b0;
  logic       osc, rclk, raise, raise_oe, lower, lower_oe, strobe, wr_out;
  logic [3:0] ph_n;
  int         bad_count = 0;
  int         checks_done = 0;
  int         cycles = 0;
  always #2.5 clk_i = ~clk_i;
  fsl_far_model u_far (.clk_i(clk_i), .strobe_i(strobe), .osc_o(osc), .phase_n_o(ph_n));
  floppy_data_recovery_precomp u_dut (
    .clk_i(clk_i), .resetn_i(resetn_i), .osc_master_i(osc), .disk_read_pulse_n_i(read_n),
    .raw_write_i(wr_data), .write_gate_i(wr_gate), .recovery_enable_fault_i(fault),
    .double_density_sel_n_i(dd_n), .inner_track_flag_i(trk), .shift_ahead_sel_i(ahead),
    .shift_behind_sel_i(behind), .phase_n_i(ph_n), .read_window_clock_o(rclk),
    .freq_raise_req_o(raise), .freq_raise_req_oe_o(raise_oe), .freq_lower_req_o(lower),
    .freq_lower_req_oe_o(lower_oe), .phase_strobe_o(strobe), .comp_write_o(wr_out));
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic check_bit(input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      give_verdict();
    end
  end
  task automatic do_reset(input logic dd);
    resetn_i <= 1'b0;
    dd_n <= dd;
    cyc(12);
    resetn_i <= 1'b1;
    cyc(4);
  endtask
  // High time of the window clock in clocks
  task automatic test_window(input int half);
    int n = 0;
    @(posedge rclk);
    while (rclk === 1'b1) begin
      cyc(1);
      n++;
    end
    check_bit(1'b1, n >= half - 3 && n <= half + 3);
    $display("window test done");
  endtask
  // Read pulse placed dly clocks after window start
  task automatic test_pump(input int dly, input logic g, input logic f,
                           input logic r, input logic l);
    wr_gate <= g;
    fault <= f;
    @(negedge rclk);
    cyc(dly);
    read_n <= 1'b0;
    cyc(8);
    check_bit(r, raise_oe);
    check_bit(l, lower_oe);
    check_bit(r, raise_oe & raise);
    check_bit(l, lower_oe & ~lower);
    cyc(10);
    check_bit(r, raise_oe);
    read_n <= 1'b1;
    cyc(6);
    check_bit(1'b0, raise_oe | lower_oe);
    wr_gate <= 1'b0;
    fault <= 1'b0;
    cyc(6);
    $display("pump test done");
  endtask
  task automatic test_precomp(input logic a, input logic b, input int sel);
    ahead <= a;
    behind <= b;
    cyc(2);
    wr_data <= 1'b1;
    cyc(5);
    check_bit(1'b1, strobe);
    for (int k = 0; k < 3; k++) begin
      cyc((k == 0) ? 15 : 20);
      check_bit(k == sel, wr_out);
    end
    cyc(10);
    check_bit(1'b1, strobe);
    cyc(15);
    check_bit(1'b0, strobe);
    wr_data <= 1'b0;
    cyc(40);
    $display("precomp test done");
  endtask
  task automatic test_bypass(input logic t);
    trk <= t;
    wr_data <= 1'b1;
    cyc(5);
    check_bit(1'b1, wr_out);
    check_bit(1'b0, strobe);
    wr_data <= 1'b0;
    cyc(5);
    check_bit(1'b0, wr_out);
    trk <= 1'b1;
    cyc(4);
    $display("bypass test done");
  endtask
  // Main sequence: double density, then single density
  initial begin
    do_reset(1'b0);
    test_window(200);
    test_pump(40, 0, 0, 1, 0);
    test_pump(175, 0, 0, 0, 0);
    test_pump(280, 0, 0, 0, 1);
    test_pump(40, 1, 0, 0, 0);
    test_pump(40, 0, 1, 0, 0);
    test_precomp(1, 0, 0);
    test_precomp(0, 0, 1);
    test_precomp(0, 1, 2);
    test_precomp(1, 1, 1);
    test_bypass(0);
    do_reset(1'b1);
    test_window(400);
    test_bypass(1);
    give_verdict();
  end
endmodule
